/* rtl/olm_pkg.sv */
// Purpose: Shared constants and types for the or-literal / move execution block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
package olm_pkg;
	localparam int          INSN_W      = 14;
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 7;
	// Opcode patterns and masks
	localparam logic [13:0] OP_IOR_MASK = 14'h3F00;
	localparam logic [13:0] OP_IOR_VAL  = 14'h3800;
	localparam logic [13:0] OP_MOV_MASK = 14'h3F00;
	localparam logic [13:0] OP_MOV_VAL  = 14'h0800;
	localparam logic [13:0] OP_STO_MASK = 14'h3F80;
	localparam logic [13:0] OP_STO_VAL  = 14'h0080;
	localparam int          DEST_BIT    = 7;
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam logic        ZERO_RESET  = 1'b0;

	typedef enum logic [1:0] {
		OLM_NONE = 2'b00,
		OLM_IOR  = 2'b01,
		OLM_MOV  = 2'b10,
		OLM_STO  = 2'b11
	} olm_op_e;

	// File register write request
	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} olm_fwr_s;
endpackage

/* rtl/olm_decode.sv */
// Purpose: Classify an instruction word among the three handled opcodes
// Assumes: Word is stable for the whole instruction cycle
// Notes:   Combinational only
`timescale 1ns/1ns
`default_nettype none
module olm_decode (
	// Instruction
	input  wire logic [13:0]    insn,
	// Decoded operation
	output olm_pkg::olm_op_e    op
);
	always_comb begin
		if ((insn & olm_pkg::OP_IOR_MASK) == olm_pkg::OP_IOR_VAL)
			op = olm_pkg::OLM_IOR;
		else if ((insn & olm_pkg::OP_MOV_MASK) == olm_pkg::OP_MOV_VAL)
			op = olm_pkg::OLM_MOV;
		else if ((insn & olm_pkg::OP_STO_MASK) == olm_pkg::OP_STO_VAL)
			op = olm_pkg::OLM_STO;
		else
			op = olm_pkg::OLM_NONE;
	end
endmodule
`default_nettype wire

/* rtl/olm_exec.sv */
// Purpose: Execute or-literal, move-file and store-accumulator instructions
// Assumes: File read data is combinational from file_raddr in the same cycle
// Notes:   One instruction per enabled cycle, no stall ever raised
//          File writes leave as a registered one-cycle strobe
//          Checks sit at the end, one cycle after each taking edge
`timescale 1ns/1ns
`default_nettype none
module olm_exec (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Instruction stream
	input  wire logic                insn_valid,
	input  wire logic [13:0]         insn,
	output logic                     insn_ready,
	// File register port
	output logic [6:0]               file_raddr,
	input  wire logic [7:0]          file_rdata,
	output olm_pkg::olm_fwr_s        file_wr,
	// Architectural state
	output logic [7:0]               acc,
	output logic                     zero_flag,
	output logic                     done
);
	logic             rst_s1_q;
	logic             rst_s2_q;
	olm_pkg::olm_op_e op;
	logic [7:0]       ior_res;
	logic [7:0]       acc_q;
	logic             zero_q;
	logic             done_q;
	olm_pkg::olm_fwr_s fwr_q;
	logic             go;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	olm_decode u_dec (
		.insn (insn),
		.op   (op)
	);

	assign insn_ready = rst_s2_q;
	assign go         = insn_valid && rst_s2_q;
	assign file_raddr = insn[6:0];
	assign ior_res    = acc_q | insn[7:0];

	// Accumulator
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			acc_q <= olm_pkg::ACC_RESET;
		end else if (go && op == olm_pkg::OLM_IOR) begin
			acc_q <= ior_res;
		end else if (go && op == olm_pkg::OLM_MOV && !insn[olm_pkg::DEST_BIT]) begin
			acc_q <= file_rdata;
		end
	end

	// Zero flag; store leaves it alone
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			zero_q <= olm_pkg::ZERO_RESET;
		end else if (go && op == olm_pkg::OLM_IOR) begin
			zero_q <= (ior_res == 8'h00);
		end else if (go && op == olm_pkg::OLM_MOV) begin
			zero_q <= (file_rdata == 8'h00);
		end
	end

	// File write-back
	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			fwr_q <= '0;
		end else begin
			fwr_q.we   <= 1'b0;
			fwr_q.addr <= insn[6:0];
			fwr_q.data <= 8'h00;
			if (go && op == olm_pkg::OLM_MOV && insn[olm_pkg::DEST_BIT]) begin
				fwr_q.we   <= 1'b1;
				fwr_q.data <= file_rdata;
			end else if (go && op == olm_pkg::OLM_STO) begin
				fwr_q.we   <= 1'b1;
				fwr_q.data <= acc_q;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_s2_q) begin
		if (!rst_s2_q)
			done_q <= 1'b0;
		else
			done_q <= go && op != olm_pkg::OLM_NONE;
	end

	assign acc       = acc_q;
	assign zero_flag = zero_q;
	assign file_wr   = fwr_q;
	assign done      = done_q;

	// Taking edges of each handled opcode
	sequence s_take_ior;
		go && op == olm_pkg::OLM_IOR;
	endsequence

	sequence s_take_mov;
		go && op == olm_pkg::OLM_MOV;
	endsequence

	sequence s_take_mov_w;
		go && op == olm_pkg::OLM_MOV && !insn[olm_pkg::DEST_BIT];
	endsequence

	sequence s_take_mov_f;
		go && op == olm_pkg::OLM_MOV && insn[olm_pkg::DEST_BIT];
	endsequence

	sequence s_take_sto;
		go && op == olm_pkg::OLM_STO;
	endsequence

	sequence s_take_any;
		go && op != olm_pkg::OLM_NONE;
	endsequence

	// Cycles that must leave the file port quiet
	sequence s_no_write;
		!(go && op == olm_pkg::OLM_STO)
			&& !(go && op == olm_pkg::OLM_MOV && insn[olm_pkg::DEST_BIT]);
	endsequence

	// Cycles that must hold acc and zero flag and raise neither done nor a file write
	sequence s_idle;
		!go || op == olm_pkg::OLM_NONE;
	endsequence

	// Checks one cycle after each taking edge
	property p_ior_result;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_ior |=> acc_q == $past(ior_res)
			&& zero_q == ($past(ior_res) == 8'h00);
	endproperty
	a_ior_result: assert property (p_ior_result)
		else $error("or literal result wrong");

	property p_mov_acc;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_mov_w |=> acc_q == $past(file_rdata) && !fwr_q.we;
	endproperty
	a_mov_acc: assert property (p_mov_acc)
		else $error("move to accumulator wrong");

	property p_mov_file;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_mov_f |=> fwr_q.we && fwr_q.data == $past(file_rdata)
			&& $stable(acc_q);
	endproperty
	a_mov_file: assert property (p_mov_file)
		else $error("move back to file wrong");

	property p_mov_addr;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_mov_f |=> fwr_q.addr == $past(file_raddr);
	endproperty
	a_mov_addr: assert property (p_mov_addr)
		else $error("move back to wrong register");

	property p_mov_zero;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_mov |=> zero_q == ($past(file_rdata) == 8'h00);
	endproperty
	a_mov_zero: assert property (p_mov_zero)
		else $error("move zero flag wrong");

	property p_sto_write;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_sto |=> fwr_q.we && fwr_q.data == $past(acc_q)
			&& fwr_q.addr == $past(insn[6:0]) && $stable(zero_q) && $stable(acc_q);
	endproperty
	a_sto_write: assert property (p_sto_write)
		else $error("store accumulator wrong");

	property p_no_stray_write;
		@(posedge clk) disable iff (!rst_s2_q)
		s_no_write |=> !fwr_q.we;
	endproperty
	a_no_stray_write: assert property (p_no_stray_write)
		else $error("file written without a write opcode");

	property p_write_addr;
		@(posedge clk) disable iff (!rst_s2_q)
		fwr_q.we |-> fwr_q.addr == $past(file_raddr);
	endproperty
	a_write_addr: assert property (p_write_addr)
		else $error("file write address wrong");

	property p_one_cycle;
		@(posedge clk) disable iff (!rst_s2_q)
		s_take_any |=> done_q;
	endproperty
	a_one_cycle: assert property (p_one_cycle)
		else $error("instruction stalled");

	property p_idle_hold;
		@(posedge clk) disable iff (!rst_s2_q)
		s_idle |=> $stable(acc_q) && $stable(zero_q) && !done_q && !fwr_q.we;
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("state changed without a handled opcode");

	property p_done_cause;
		@(posedge clk) disable iff (!rst_s2_q)
		done_q |-> $past(go && op != olm_pkg::OLM_NONE);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done raised without an instruction");
endmodule
`default_nettype wire

/* tb/test_or_literal_and_move_ops.sv */
// Purpose: Self-checking bench for olm_exec
// Assumes: Bench stands in for the file register port
// Notes:   Outputs checked 1 ns after the taking edge
`timescale 1ns/1ns
`default_nettype none
module test_or_literal_and_move_ops;
	logic              clk, nrst, insn_valid, insn_ready, zero_flag, done;
	logic [13:0]       insn;
	logic [6:0]        file_raddr;
	logic [7:0]        file_rdata, acc;
	olm_pkg::olm_fwr_s file_wr;
	int                n_fail, samples_checked;
	olm_exec i_dut (.clk(clk), .nrst(nrst), .insn_valid(insn_valid), .insn(insn),
		.insn_ready(insn_ready), .file_raddr(file_raddr), .file_rdata(file_rdata),
		.file_wr(file_wr), .acc(acc), .zero_flag(zero_flag), .done(done));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatched %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Issue one word, return just after its results land
	task automatic issue(input logic [13:0] w, input logic [7:0] rd);
		@(posedge clk);
		insn <= w;
		file_rdata <= rd;
		insn_valid <= 1'b1;
		@(posedge clk);
		insn_valid <= 1'b0;
		file_rdata <= ~rd;
		#1;
	endtask
	task automatic t_reset();
		chk("acc", acc, 16'h0000);
		chk("ready", insn_ready, 16'h0001);
		chk("done", done, 16'h0000);
		chk("reset z", zero_flag, 16'h0000);
		chk("reset we", file_wr.we, 16'h0000);
		$display("reset done");
	endtask
	task automatic t_ior();
		issue(14'h0805, 8'h9A);
		issue(14'h3835, 8'h00);
		chk("ior acc", acc, 16'h00BF);
		chk("ior z", zero_flag, 16'h0000);
		chk("ior done", done, 16'h0001);
		issue(14'h0805, 8'h00);
		issue(14'h3800, 8'h55);
		chk("ior z0", zero_flag, 16'h0001);
		$display("ior done");
	endtask
	task automatic t_mov();
		issue(14'h0805, 8'h80);
		chk("mov acc", acc, 16'h0080);
		chk("mov z", zero_flag, 16'h0000);
		chk("mov we", file_wr.we, 16'h0000);
		issue(14'h08FF, 8'h00);
		chk("mov wr", {file_wr.we, file_wr.addr, file_wr.data}, 16'hFF00);
		chk("mov z1", zero_flag, 16'h0001);
		chk("mov keep", acc, 16'h0080);
		chk("mov raddr", file_raddr, 16'h007F);
		$display("mov done");
	endtask
	task automatic t_sto();
		issue(14'h00FF, 8'h00);
		chk("sto wr", {file_wr.we, file_wr.addr, file_wr.data}, 16'hFF80);
		chk("sto z", zero_flag, 16'h0001);
		@(posedge clk);
		#1;
		chk("we pulse", file_wr.we, 16'h0000);
		issue(14'h0000, 8'h00);
		chk("nop done", done, 16'h0000);
		$display("sto done");
	endtask
	task automatic t_rst_mid();
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst acc", acc, 16'h0000);
		chk("rst z", zero_flag, 16'h0000);
		chk("rst ready", insn_ready, 16'h0000);
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk("rst wait", insn_ready, 16'h0000);
		@(posedge clk);
		#1;
		chk("rst ready2", insn_ready, 16'h0001);
		$display("mid reset done");
	endtask
	task automatic t_burst();
		issue(14'h0805, 8'h00);
		@(posedge clk);
		insn <= 14'h3801;
		insn_valid <= 1'b1;
		@(posedge clk);
		insn <= 14'h3802;
		@(posedge clk);
		insn_valid <= 1'b0;
		#1;
		chk("burst acc", acc, 16'h0003);
		chk("burst done", done, 16'h0001);
		@(posedge clk);
		insn <= 14'h3810;
		@(posedge clk);
		#1;
		chk("idle acc", acc, 16'h0003);
		chk("idle done", done, 16'h0000);
		$display("burst done");
	endtask
	initial begin
		#20000;
		n_fail++;
		final_report();
	end
	initial begin
		nrst = 1'b0;
		insn_valid = 1'b0;
		insn = 14'h0000;
		file_rdata = 8'h00;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_reset();
		t_ior();
		t_mov();
		t_sto();
		t_rst_mid();
		t_burst();
		final_report();
	end
endmodule
`default_nettype wire
